/* src/anl_pkg.sv */
package anl_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // timer set
    localparam int NUM_TIMERS = 10;
    localparam int TMR_W      = 28;

    localparam int TMR_WAIT       = 0;
    localparam int TMR_BREAK      = 1;
    localparam int TMR_DD_MIN     = 2;
    localparam int TMR_DD_MAX     = 3;
    localparam int TMR_FLP_MAX    = 4;
    localparam int TMR_FLP_MIN    = 5;
    localparam int TMR_INTERVAL   = 6;
    localparam int TMR_LF_INHIBIT = 7;
    localparam int TMR_NLP_MAX    = 8;
    localparam int TMR_NLP_MIN    = 9;
    localparam int TMR_BURST      = 10;

    // least expiry times in ns; expiring at the least time keeps inside range
    localparam int WAIT_MIN_NS       = 500_000_000;
    localparam int BREAK_MIN_NS      = 1_200_000_000;
    localparam int DD_MIN_MIN_NS     = 15_000;
    localparam int DD_MAX_MIN_NS     = 78_000;
    localparam int FLP_MAX_MIN_NS    = 165_000;
    localparam int FLP_MIN_MIN_NS    = 5_000;
    localparam int INTERVAL_MIN_NS   = 55_500;
    localparam int LF_INHIBIT_MIN_NS = 750_000_000;
    localparam int NLP_MAX_MIN_NS    = 50_000_000;
    localparam int NLP_MIN_MIN_NS    = 5_000_000;
    localparam int BURST_MIN_NS      = 5_700_000;

    localparam logic [TMR_W-1:0] WAIT_CYC =
        TMR_W'((WAIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] BREAK_CYC =
        TMR_W'((BREAK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] DD_MIN_CYC =
        TMR_W'((DD_MIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] DD_MAX_CYC =
        TMR_W'((DD_MAX_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] FLP_MAX_CYC =
        TMR_W'((FLP_MAX_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] FLP_MIN_CYC =
        TMR_W'((FLP_MIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] INTERVAL_CYC =
        TMR_W'((INTERVAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] LF_INHIBIT_CYC =
        TMR_W'((LF_INHIBIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] NLP_MAX_CYC =
        TMR_W'((NLP_MAX_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] NLP_MIN_CYC =
        TMR_W'((NLP_MIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] BURST_CYC =
        TMR_W'((BURST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // link control and link status codes
    typedef enum logic [1:0] {
        LC_DISABLE = 2'h0,
        LC_SCAN    = 2'h1,
        LC_ENABLE  = 2'h2
    } anl_link_ctrl_type;

    localparam logic [1:0] LS_FAIL  = 2'h0;
    localparam logic [1:0] LS_READY = 2'h1;
    localparam logic [1:0] LS_OK    = 2'h2;

    // register map (byte addresses)
    localparam logic [7:0] REG_CTRL        = 8'h00;
    localparam logic [7:0] REG_LINK_STAT   = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT    = 8'h08;
    localparam logic [7:0] REG_IRQ_CLR     = 8'h0C;
    localparam logic [7:0] REG_IRQ_EN      = 8'h10;
    localparam logic [7:0] REG_TMR_RESTART = 8'h14;
    localparam logic [7:0] REG_TMR_STAT    = 8'h18;

    // control and status fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SEL_LSB  = 4;
    localparam int LSTAT_NRDY_LSB = 16;
    localparam int TSTAT_RUN_LSB  = 16;

    // interrupt status bits
    localparam int IRQ_W        = 3;
    localparam int IRQ_PD_FAULT = 0;
    localparam int IRQ_WAIT_DONE = 1;
    localparam int IRQ_TMR_EXP  = 2;

    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

endpackage : anl_pkg

/* src/anl_link_ctrl.sv */
// Notes on behaviour
// R1: each PMA reports exactly one of READY, OK or FAIL.
// R2: under scan-for-carrier a PMA only searches carrier and reports READY.
// R3: enable goes to a single PMA only; never two at once.
// R4: after reset every PMA is driven DISABLE.
// R5: where unclear, the negotiation state machines define behaviour.
// R6: wait timer expires 500 to 1000 ms after start.
// R7: break-link timer expires 1200 to 1500 ms after start.
// R8: data-detect minimum timer expires 15 to 47 us after last clock pulse.
// R9: data-detect maximum timer expires 78 to 100 us after last pulse.
// R10: FLP test maximum timer expires 165 to 185 us after last link pulse.
// R11: FLP test minimum timer expires 5 to 25 us after last link pulse.
// R12: interval timer restarts per sent pulse, expires 55.5 to 69.5 us later.
// R13: link-fail-inhibit timer expires 750 to 1000 ms after link-good-check.
// R14: NLP test maximum timer expires 50 to 150 ms unless restarted.
// R15: NLP test minimum timer expires 5 to 7 ms unless restarted.
// R16: burst timer expires 5.7 to 22.3 ms after last burst pulse.
// R17: at wait expiry, zero or several READY PMAs flag a detection fault.
// R18: each timer is a clock counter with a design-time terminal count.
// R19: each timer has a restart and an expiry flag held until restart.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
module anl_link_ctrl #(
    parameter int                         NUM_PMA     = 3,
    parameter logic [anl_pkg::TMR_W-1:0] WAIT_CYC     = anl_pkg::WAIT_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] BREAK_CYC    = anl_pkg::BREAK_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] DD_MIN_CYC   = anl_pkg::DD_MIN_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] DD_MAX_CYC   = anl_pkg::DD_MAX_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] FLP_MAX_CYC  = anl_pkg::FLP_MAX_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] FLP_MIN_CYC  = anl_pkg::FLP_MIN_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] INTERVAL_CYC =
        anl_pkg::INTERVAL_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] LF_INH_CYC   =
        anl_pkg::LF_INHIBIT_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] NLP_MAX_CYC  = anl_pkg::NLP_MAX_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] NLP_MIN_CYC  = anl_pkg::NLP_MIN_CYC,
    parameter logic [anl_pkg::TMR_W-1:0] BURST_CYC    = anl_pkg::BURST_CYC
) (
    // clock and reset
    input  wire logic                              clk_in,
    input  wire logic                              rstn_in,
    // register port
    input  wire logic [7:0]                        addr_in,
    input  wire logic [31:0]                       wr_data_in,
    input  wire logic                              wr_en_in,
    input  wire logic                              rd_en_in,
    output logic      [31:0]                       rd_data_out,
    // technology-dependent PMAs
    input  wire logic [NUM_PMA-1:0][1:0]           link_status_in,
    output logic      [NUM_PMA-1:0][1:0]           link_ctrl_out,
    // timers towards the negotiation state machines
    input  wire logic [anl_pkg::NUM_TIMERS:0]      timer_restart_in,
    output logic      [anl_pkg::NUM_TIMERS:0]      timer_expired_out,
    // interrupt
    output logic                                   irq_out
);

    localparam int NT    = anl_pkg::NUM_TIMERS + 1;
    localparam int TW    = anl_pkg::TMR_W;
    localparam int SEL_W = (NUM_PMA > 1) ? $clog2(NUM_PMA) : 1;
    localparam int IW    = anl_pkg::IRQ_W;

    // terminal counts, index order follows the package timer indices
    localparam logic [NT-1:0][TW-1:0] TERM = {
        BURST_CYC, NLP_MIN_CYC, NLP_MAX_CYC, LF_INH_CYC, INTERVAL_CYC,
        FLP_MIN_CYC, FLP_MAX_CYC, DD_MAX_CYC, DD_MIN_CYC, BREAK_CYC, WAIT_CYC
    };                                                          // [R18]

    typedef struct packed {
        logic [1:0]                 mode;
        logic [SEL_W-1:0]           sel;
        logic [NUM_PMA-1:0][1:0]    link_ctrl;
        logic [NT-1:0][TW-1:0]      cnt;
        logic [NT-1:0]              run;
        logic [NT-1:0]              expired;
        logic [IW-1:0]              irq_stat;
        logic [IW-1:0]              irq_en;
        logic                       irq;
        logic [31:0]                rd_data;
    } anl_state_type;

    anl_state_type st_ff;
    anl_state_type nxt_st;

    logic [NT-1:0] restart;
    logic [NT-1:0] hit;
    logic [7:0]    nrdy;
    logic [IW-1:0] ev;

    always_comb begin
        nxt_st  = st_ff;
        restart = timer_restart_in;
        hit     = '0;
        nrdy    = 8'h00;
        ev      = '0;

        if (wr_en_in && addr_in == anl_pkg::REG_TMR_RESTART) begin
            restart = restart | wr_data_in[NT-1:0];
        end

        // timers: restart clears count and flag; flag holds until restart
        for (int i = 0; i < NT; i++) begin
            if (restart[i]) begin
                nxt_st.cnt[i]     = '0;                         // [R19]
                nxt_st.run[i]     = 1'b1;
                nxt_st.expired[i] = 1'b0;
            end else if (st_ff.run[i]) begin
                if (st_ff.cnt[i] == TERM[i] - 1'b1) begin       // [R6] [R7]
                    hit[i]            = 1'b1;                   // [R8] [R9]
                    nxt_st.expired[i] = 1'b1;                   // [R10] [R11]
                    nxt_st.run[i]     = 1'b0;                   // [R12] [R13]
                end else begin                                  // [R14] [R15]
                    nxt_st.cnt[i] = st_ff.cnt[i] + 1'b1;        // [R16]
                end
            end
        end

        // only the READY code counts; OK and FAIL do not
        for (int p = 0; p < NUM_PMA; p++) begin
            if (link_status_in[p] == anl_pkg::LS_READY) begin   // [R1]
                nrdy = nrdy + 8'h01;
            end
        end

        ev[anl_pkg::IRQ_WAIT_DONE] = hit[anl_pkg::TMR_WAIT];
        ev[anl_pkg::IRQ_PD_FAULT]  = hit[anl_pkg::TMR_WAIT]
                                     && nrdy != 8'h01;          // [R17]
        ev[anl_pkg::IRQ_TMR_EXP]   = |hit;

        if (wr_en_in) begin
            unique case (addr_in)
                anl_pkg::REG_CTRL: begin
                    nxt_st.mode = wr_data_in[anl_pkg::CTRL_MODE_LSB +: 2];
                    nxt_st.sel  = wr_data_in[anl_pkg::CTRL_SEL_LSB +: SEL_W];
                end
                anl_pkg::REG_IRQ_CLR: begin
                    nxt_st.irq_stat = st_ff.irq_stat & ~wr_data_in[IW-1:0];
                end
                anl_pkg::REG_IRQ_EN: begin
                    nxt_st.irq_en = wr_data_in[IW-1:0];
                end
                default: begin
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        nxt_st.irq_stat = nxt_st.irq_stat | ev;
        nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_en);

        // link control: all disabled unless scanning or one PMA enabled
        for (int p = 0; p < NUM_PMA; p++) begin
            nxt_st.link_ctrl[p] = anl_pkg::LC_DISABLE;          // [R4]
            if (nxt_st.mode == anl_pkg::LC_SCAN) begin
                nxt_st.link_ctrl[p] = anl_pkg::LC_SCAN;         // [R2]
            end else if (nxt_st.mode == anl_pkg::LC_ENABLE
                         && p == int'(nxt_st.sel)) begin
                nxt_st.link_ctrl[p] = anl_pkg::LC_ENABLE;       // [R3] [R5]
            end
        end

        nxt_st.rd_data = 32'h0000_0000;
        if (rd_en_in) begin
            unique case (addr_in)
                anl_pkg::REG_CTRL: begin
                    nxt_st.rd_data[anl_pkg::CTRL_MODE_LSB +: 2] =
                        st_ff.mode;
                    nxt_st.rd_data[anl_pkg::CTRL_SEL_LSB +: SEL_W] =
                        st_ff.sel;
                end
                anl_pkg::REG_LINK_STAT: begin
                    nxt_st.rd_data[2*NUM_PMA-1:0] = link_status_in;
                    nxt_st.rd_data[anl_pkg::LSTAT_NRDY_LSB +: 8] = nrdy;
                end
                anl_pkg::REG_IRQ_STAT: begin
                    nxt_st.rd_data[IW-1:0] = st_ff.irq_stat;
                end
                anl_pkg::REG_IRQ_EN: begin
                    nxt_st.rd_data[IW-1:0] = st_ff.irq_en;
                end
                anl_pkg::REG_TMR_STAT: begin
                    nxt_st.rd_data[NT-1:0] = st_ff.expired;
                    nxt_st.rd_data[anl_pkg::TSTAT_RUN_LSB +: NT] =
                        st_ff.run;
                end
                default: begin
                end
            endcase
        end
    end

    // all-zero reset: mode and every link control read DISABLE
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= '0;                                        // [R4]
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data_out       = st_ff.rd_data;
    assign link_ctrl_out     = st_ff.link_ctrl;
    assign timer_expired_out = st_ff.expired;
    assign irq_out           = st_ff.irq;

endmodule : anl_link_ctrl

/* sim/anl_link_ctrl_properties.sv */
module anl_link_ctrl_chk #(
    parameter int NUM_PMA = 3,
    parameter int WAIT_T  = 20
) (
    // watched ports
    input wire logic                         clk_in,
    input wire logic                         rstn_in,
    input wire logic [7:0]                   addr_in,
    input wire logic [31:0]                  wr_data_in,
    input wire logic                         wr_en_in,
    input wire logic [NUM_PMA-1:0][1:0]      link_ctrl_out,
    input wire logic [anl_pkg::NUM_TIMERS:0] timer_restart_in,
    input wire logic [anl_pkg::NUM_TIMERS:0] timer_expired_out,
    input wire logic                         irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int   en_n;
    logic cw;
    always_comb begin
        en_n = 0;
        for (int i = 0; i < NUM_PMA; i++) begin
            en_n += int'(link_ctrl_out[i] == 2'h2);
        end
    end
    assign cw = wr_en_in && addr_in == 8'h00 && wr_data_in[31:6] == '0;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_reset_quiet: assert property ($rose(rstn_in) |->
        link_ctrl_out == '0 && timer_expired_out == '0 && !irq_out)
        else $error("outputs not idle after reset");
    a_one_enable: assert property (en_n <= 1)
        else $error("several units enabled");
    a_scan_all: assert property (cw && wr_data_in[1:0] == 2'h1
        |=> link_ctrl_out == {NUM_PMA{2'h1}}) else $error("scan not sent");
    a_disable_all: assert property (cw && wr_data_in[1:0] == 2'h0
        |=> link_ctrl_out == '0) else $error("disable not sent");
    a_enable_sel: assert property (cw && wr_data_in[1:0] == 2'h2
        && wr_data_in[5:4] < NUM_PMA
        |=> link_ctrl_out[$past(wr_data_in[5:4])] == 2'h2)
        else $error("selected unit not enabled");
    a_flag_holds: assert property ($past(wr_en_in && addr_in == 8'h14)
        || ($past(timer_expired_out & ~timer_restart_in)
        & ~timer_expired_out) == '0) else $error("expiry flag dropped");
    a_restart_clr: assert property (|timer_restart_in |=>
        (timer_expired_out & $past(timer_restart_in)) == '0)
        else $error("restart left flag set");
    a_wait_late: assert property ($rose(timer_expired_out[0]) |->
        $past(timer_restart_in[0], WAIT_T + 1)) else $error("wait expiry off");
    a_wait_early: assert property (timer_restart_in[0] |=>
        !timer_expired_out[0] [*8]) else $error("wait expired early");
    c_irq: cover property (irq_out);
    c_wait: cover property ($rose(timer_expired_out[0]));
    c_enable: cover property (en_n == 1);
endmodule : anl_link_ctrl_chk

bind anl_link_ctrl anl_link_ctrl_chk #(
    .NUM_PMA(NUM_PMA), .WAIT_T(int'(WAIT_CYC))
) anl_link_ctrl_chk_i (
    .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
    .link_ctrl_out(link_ctrl_out), .timer_restart_in(timer_restart_in),
    .timer_expired_out(timer_expired_out), .irq_out(irq_out)
);

/* sim/anl_pma_model.sv */
module anl_pma_model #(
    parameter int NUM_PMA = 3
) (
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rstn_in,
    // medium and control
    input  wire logic [NUM_PMA-1:0]      carrier_in,
    input  wire logic [NUM_PMA-1:0][1:0] link_ctrl_in,
    output logic      [NUM_PMA-1:0][1:0] link_status_out
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link_status_out <= '0;
        end else begin
            for (int i = 0; i < NUM_PMA; i++) begin
                case (link_ctrl_in[i])
                    2'h1: link_status_out[i] <= carrier_in[i] ?
                        anl_pkg::LS_READY : anl_pkg::LS_FAIL;
                    2'h2: link_status_out[i] <= anl_pkg::LS_OK;
                    default: link_status_out[i] <= anl_pkg::LS_FAIL;
                endcase
            end
        end
    end
endmodule : anl_pma_model

/* sim/anl_link_ctrl_tb_top.sv */
module anl_link_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    int   err_total = 0;
    int   checked   = 0;
    int   cyc       = 0;
    int   n;
    logic flt;
    logic [2:0]  pats [4] = '{3'h0, 3'h3, 3'h2, 3'h7};
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [7:0]  addr_in = '0;
    logic [31:0] wr_data_in = '0;
    logic        wr_en_in = 1'b0;
    logic        rd_en_in = 1'b0;
    logic [31:0] rd_data_out;
    logic [2:0]  carrier = '0;
    logic [2:0][1:0] lstat;
    logic [2:0][1:0] lctl;
    logic [10:0] timer_restart_in = '0;
    logic [10:0] timer_expired_out;
    logic        irq_out;

    // short terminal counts for simulation, timer i expires after tc(i)
    function automatic logic [27:0] tc(input int i);
        return 28'(20 + 4 * i);
    endfunction : tc

    anl_link_ctrl #(
        .WAIT_CYC(tc(0)), .BREAK_CYC(tc(1)),
        .DD_MIN_CYC(tc(2)), .DD_MAX_CYC(tc(3)), .FLP_MAX_CYC(tc(4)),
        .FLP_MIN_CYC(tc(5)), .INTERVAL_CYC(tc(6)), .LF_INH_CYC(tc(7)),
        .NLP_MAX_CYC(tc(8)), .NLP_MIN_CYC(tc(9)), .BURST_CYC(tc(10))
    ) anl_link_ctrl_i (
        .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .link_status_in(lstat),
        .link_ctrl_out(lctl), .timer_restart_in(timer_restart_in),
        .timer_expired_out(timer_expired_out), .irq_out(irq_out));
    anl_pma_model anl_pma_model_i (.clk_in(clk_in),
        .rstn_in(rstn_in), .carrier_in(carrier), .link_ctrl_in(lctl),
        .link_status_out(lstat));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 chk(nm, e, rd_data_out);
    endtask : rd
    task automatic pulse(input int i);
        @(posedge clk_in);
        timer_restart_in[i] <= 1'b1;
        @(posedge clk_in);
        timer_restart_in[i] <= 1'b0;
    endtask : pulse
    // counts edges from the restart edge until the flag rises
    task automatic meas(input int i);
        #1 n = 0;
        while (n < 100 && timer_expired_out[i] !== 1'b1) begin
            @(posedge clk_in);
            #1 n++;
        end
        chk($sformatf("timer %0d", i), 32'(tc(i)), 32'(n));
    endtask : meas
    task automatic ctl(input logic [31:0] d, input logic [5:0] c, s);
        wr(8'h00, d);
        repeat (2) @(posedge clk_in);
        #1 chk("link control", 32'(c), 32'(lctl));
        rd(8'h04, {8'h0, (c == 6'h15) ? 8'h3 : 8'h0, 10'h0, s}, "status");
        rd(8'h00, d, "control");
    endtask : ctl

    initial begin
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        #1 chk("control at reset", 32'h0, 32'(lctl));
        for (int a = 0; a < 8; a++) begin
            rd(8'(4 * a), 32'h0, "reset value");
        end
        wr(8'h08, 32'h7);
        wr(8'h1C, 32'h7);
        rd(8'h08, 32'h0, "read-only status");
        rd(8'h1C, 32'h0, "unmapped");
        @(posedge clk_in);
        carrier <= 3'h7;
        ctl(32'h00, 6'h00, 6'h00);
        ctl(32'h02, 6'h02, 6'h02);
        ctl(32'h12, 6'h08, 6'h08);
        ctl(32'h22, 6'h20, 6'h20);
        ctl(32'h32, 6'h00, 6'h00);
        ctl(32'h03, 6'h00, 6'h00);
        ctl(32'h01, 6'h15, 6'h15);
        wr(8'h10, 32'h1);
        for (int p = 0; p < 4; p++) begin
            flt = ($countones(pats[p]) != 1);
            @(posedge clk_in);
            carrier <= pats[p];
            wr(8'h0C, 32'h7);
            repeat (2) @(posedge clk_in);
            #1 chk("irq after clear", 32'h0, 32'(irq_out));
            pulse(0);
            meas(0);
            @(posedge clk_in);
            #1 chk("fault irq", 32'(flt), 32'(irq_out));
            rd(8'h08, {29'h0, 2'h3, flt}, "irq status");
        end
        wr(8'h10, 32'h0);
        repeat (2) @(posedge clk_in);
        #1 chk("masked irq", 32'h0, 32'(irq_out));
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 11; i++) begin
                if (p == 0) begin
                    pulse(i);
                    repeat (5) @(posedge clk_in);
                end
                pulse(i);
                meas(i);
            end
        end
        rd(8'h18, 32'h0000_07FF, "timer status");
        wr(8'h14, 32'h40);
        meas(6);
        // reset in mid-run while scanning with every flag set
        @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 chk("control in reset", 32'h0, 32'(lctl));
        chk("expiry in reset", 32'h0, 32'(timer_expired_out));
        @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        #1 chk("control after reset", 32'h0, 32'(lctl));
        rd(8'h18, 32'h0, "timer status after reset");
        rd(8'h00, 32'h0, "control after reset");
        stop_test();
    end
endmodule : anl_link_ctrl_tb_top
